// [src/monitor_adc_serial_select.sv]
`timescale 1ns/1ps
// converter bank: chip-select decode plus the serial engine of the addressed converter
module monitor_adc_serial_select (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          monitor_serial_clock,
    input  wire logic                          monitor_serial_in,
    input  wire logic                          conv_chip_sel_bit0,
    input  wire logic                          conv_chip_sel_bit1,
    input  wire logic                          conv_chip_sel_bit2,
    input  wire logic                          conv_chip_sel_bit3,
    input  wire logic [mon_adc_pkg::RESULT_W-1:0] conv_value,
    output logic                               monitor_serial_out,
    output logic [mon_adc_pkg::NUM_CHIPS-1:0]  chip_enable,
    output logic [mon_adc_pkg::SEL_W-1:0]      conv_chip,
    output mon_adc_pkg::conv_cfg_t             conv_cfg,
    output logic                               frame_active
);
    import mon_adc_pkg::*;

    // synchronised pins: serial clock, data in, select code
    logic [SEL_W+1:0]     pins_s;
    logic                 sclk_s;        // serial clock in mclk domain
    logic                 sdin_s;        // serial data in, mclk domain
    logic [SEL_W-1:0]     sel_s;         // select code, mclk domain

    // edge detection and select tracking
    logic                 sclk_prev_ff;  // serial clock one mclk ago
    logic [SEL_W-1:0]     sel_prev_ff;   // select code one mclk ago
    logic                 sclk_rise;     // we sample the serial input here
    logic                 sclk_fall;     // we drive the next output bit here
    logic                 sel_ok;        // code names a fitted chip
    logic                 abort;         // deselect or code change ends a frame

    // frame engine state
    frame_state_t         state_ff, nxt_state;
    logic [CNT_W-1:0]     cnt_ff, nxt_cnt;            // serial clock rises in this frame
    logic [CTRL_W-1:0]    shin_ff, nxt_shin;          // control byte being collected
    logic [CTRL_W-1:0]    byte_ff, nxt_byte;          // last accepted control byte
    logic [DATA_CLOCKS-1:0] shout_ff, nxt_shout;      // result bits still to send
    logic                 loaded_ff, nxt_loaded;      // result captured for this frame
    logic                 sout_ff, nxt_sout;          // serial out level
    logic [NUM_CHIPS-1:0] cen_ff, nxt_cen;            // decoded chip enables
    logic [SEL_W-1:0]     chip_ff, nxt_chip;          // chip the result belongs to
    conv_cfg_t            cfg_ff, nxt_cfg;            // decoded configuration
    logic                 act_ff, nxt_act;            // frame in progress
    logic [CTRL_W-1:0]    full_byte;                  // byte completed by this rise
    ctrl_byte_t           cb;                         // that byte as fields
    logic [DATA_CLOCKS-1:0] frame_bits;               // null bit, result, zero tail

    // one synchroniser for all slow pins; clock and data share its latency so their order holds
    sync2 #(.W(SEL_W + 2)) sync2_inst (
        .mclk     (mclk),
        .rst      (rst),
        .async_in ({conv_chip_sel_bit3, conv_chip_sel_bit2, conv_chip_sel_bit1, conv_chip_sel_bit0,
                    monitor_serial_in, monitor_serial_clock}),
        .sync_out (pins_s)
    );

    // split the bundle and find edges and the abort condition
    always_comb begin
        sclk_s     = pins_s[0];
        sdin_s     = pins_s[1];
        sel_s      = pins_s[SEL_W+1:2];
        sclk_rise  = sclk_s & ~sclk_prev_ff;
        sclk_fall  = ~sclk_s & sclk_prev_ff;
        sel_ok     = (sel_s <= LAST_CODE);
        abort      = ~sel_ok | (sel_s != sel_prev_ff);
        full_byte  = {shin_ff[CTRL_W-2:0], sdin_s};
        cb         = ctrl_byte_t'(full_byte);
        // one null clock, then the result msb first, then zeros
        frame_bits = {1'h0, conv_value, {TAIL_W{1'h0}}};
    end

    // chip-select decode: one enable for codes 0..11, none above
    always_comb begin
        nxt_cen = '0;
        if (sel_ok) begin
            nxt_cen = NUM_CHIPS'(1) << sel_s;
        end
    end

    // frame engine next values
    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_shin   = shin_ff;
        nxt_byte   = byte_ff;
        nxt_shout  = shout_ff;
        nxt_loaded = loaded_ff;
        nxt_sout   = sout_ff;
        nxt_chip   = chip_ff;
        nxt_cfg    = cfg_ff;
        if (abort) begin
            // a select change mid-frame leaves the converter waiting for a new start bit
            nxt_state  = ST_IDLE;
            nxt_sout   = 1'h0;
            nxt_loaded = 1'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    // leading zeros are ignored; the first one is the start bit
                    if (sclk_rise && sdin_s) begin
                        nxt_state = ST_CTRL;
                        nxt_cnt   = CNT_FIRST;
                        nxt_shin  = START_SEED;
                    end
                end
                ST_CTRL: begin
                    if (sclk_rise) begin
                        nxt_shin = full_byte;
                        nxt_cnt  = cnt_ff + CNT_FIRST;
                        if (cnt_ff == CNT_BYTE_DONE) begin
                            // decode the byte; all ones gives ch7, single-ended, external clock
                            nxt_byte             = full_byte;
                            nxt_cfg.mode         = cb.mode;
                            nxt_cfg.unipolar     = cb.unipolar;
                            nxt_cfg.single_ended = cb.single_ended;
                            // channel weights are not in bit order: bit 5 is 4, bit 4 is 2, bit 6 is 1
                            nxt_cfg.channel      = {cb.chan_raw[1], cb.chan_raw[0], cb.chan_raw[2]};
                            nxt_chip             = sel_s;
                            nxt_state            = ST_DATA;
                            nxt_loaded           = 1'h0;
                        end
                    end
                end
                ST_DATA: begin
                    // the result is taken at the first falling edge, well after channel settles
                    if (sclk_fall) begin
                        if (!loaded_ff) begin
                            nxt_sout   = frame_bits[DATA_CLOCKS-1];
                            nxt_shout  = frame_bits << 1;
                            nxt_loaded = 1'h1;
                        end else begin
                            nxt_sout   = shout_ff[DATA_CLOCKS-1];
                            nxt_shout  = shout_ff << 1;
                        end
                    end
                    if (sclk_rise) begin
                        nxt_cnt = cnt_ff + CNT_FIRST;
                        if (cnt_ff == CNT_FRAME_END) begin
                            nxt_state  = ST_IDLE;
                            nxt_sout   = 1'h0;
                            nxt_loaded = 1'h0;
                        end
                    end
                end
            endcase
        end
        nxt_act = (nxt_state != ST_IDLE);
    end

    // register every group; outputs all come from these flops
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_prev_ff <= 1'h0;
            sel_prev_ff  <= '0;
            state_ff     <= ST_IDLE;
            cnt_ff       <= '0;
            shin_ff      <= '0;
            byte_ff      <= '0;
            shout_ff     <= '0;
            loaded_ff    <= 1'h0;
            sout_ff      <= 1'h0;
            cen_ff       <= '0;
            chip_ff      <= '0;
            cfg_ff       <= '0;
            act_ff       <= 1'h0;
        end else begin
            sclk_prev_ff <= sclk_s;
            sel_prev_ff  <= sel_s;
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            shin_ff      <= nxt_shin;
            byte_ff      <= nxt_byte;
            shout_ff     <= nxt_shout;
            loaded_ff    <= nxt_loaded;
            sout_ff      <= nxt_sout;
            cen_ff       <= nxt_cen;
            chip_ff      <= nxt_chip;
            cfg_ff       <= nxt_cfg;
            act_ff       <= nxt_act;
        end
    end

    always_comb begin
        monitor_serial_out = sout_ff;
        chip_enable        = cen_ff;
        conv_chip          = chip_ff;
        conv_cfg           = cfg_ff;
        frame_active       = act_ff;
    end

    // checks on the decode and the frame engine
    default clocking cb_mclk @(posedge mclk); endclocking
    default disable iff (rst);

    a_decode_idle_codes: assert property ((sel_s > LAST_CODE) |=> (cen_ff == '0))
        else $error("code above eleven enabled a chip");
    a_decode_one_hot: assert property ($onehot0(cen_ff))
        else $error("more than one chip enabled");
    a_decode_ascending: assert property ((sel_s <= LAST_CODE) |=> (cen_ff == (NUM_CHIPS'(1) << $past(sel_s))))
        else $error("wrong chip enabled for code");
    a_start_bit_needed: assert property ((state_ff == ST_IDLE && sclk_rise && !sdin_s) |=> (state_ff == ST_IDLE))
        else $error("frame began without a start bit");
    a_frame_count_span: assert property ((state_ff == ST_DATA) |-> (cnt_ff > CNT_BYTE_DONE && cnt_ff <= CNT_FRAME_END))
        else $error("data phase outside clocks 9 to 24");
    a_frame_end_idle: assert property ((state_ff == ST_DATA && sclk_rise && cnt_ff == CNT_FRAME_END && !abort)
                                       |=> (state_ff == ST_IDLE && !sout_ff))
        else $error("frame did not end at clock 24");
    a_channel_bit_order: assert property ($rose(state_ff == ST_DATA)
                                          |-> (cfg_ff.channel == {byte_ff[5], byte_ff[4], byte_ff[6]}))
        else $error("channel bits in wrong order");
    a_mode_and_flags: assert property ($rose(state_ff == ST_DATA)
                                       |-> (cfg_ff.mode == conv_mode_t'(byte_ff[1:0]) && cfg_ff.unipolar == byte_ff[3]
                                            && cfg_ff.single_ended == byte_ff[2]))
        else $error("mode or input flags misdecoded");
    a_all_ones_byte: assert property ((state_ff == ST_DATA && byte_ff == 8'hFF)
                                      |-> (cfg_ff.channel == 3'h7 && cfg_ff.single_ended && cfg_ff.mode == MODE_EXT_CLK))
        else $error("all-ones byte misdecoded");
    a_out_shift_step: assert property ((state_ff == ST_DATA && sclk_fall && loaded_ff && !abort)
                                       |=> (sout_ff == $past(shout_ff[DATA_CLOCKS-1])))
        else $error("serial out did not follow the result shifter");
    a_out_quiet_idle: assert property ((state_ff == ST_IDLE) |-> !sout_ff)
        else $error("serial out driven outside a frame");

    c_frame_complete: cover property (state_ff == ST_DATA && sclk_rise && cnt_ff == CNT_FRAME_END);
    c_all_ones_byte: cover property ($rose(state_ff == ST_DATA) && byte_ff == 8'hFF);
    c_invalid_code: cover property (sel_s > LAST_CODE && act_ff);
    c_last_chip: cover property (cen_ff[NUM_CHIPS-1]);

endmodule

// [src/mon_adc_pkg.sv]
package mon_adc_pkg;

    localparam int unsigned NUM_CHIPS   = 12;   // converters in the bank
    localparam int unsigned SEL_W       = 4;    // chip-select code width
    localparam int unsigned CTRL_W      = 8;    // control byte width
    localparam int unsigned CHAN_W      = 3;    // channel number width
    localparam int unsigned RESULT_W    = 12;   // conversion result width
    localparam int unsigned DATA_CLOCKS = 16;   // clocks after the control byte
    localparam int unsigned FRAME_CLKS  = 24;   // clocks in a whole transaction
    localparam int unsigned CNT_W       = 5;    // width of the clock counter
    localparam int unsigned TAIL_W      = DATA_CLOCKS - RESULT_W - 1;  // zero bits after the result

    localparam logic [CNT_W-1:0]    CNT_BYTE_DONE = 5'h07;  // rises seen before the last control bit
    localparam logic [CNT_W-1:0]    CNT_FRAME_END = 5'h17;  // rises seen before the last frame clock
    localparam logic [CNT_W-1:0]    CNT_FIRST     = 5'h01;  // counter after the start bit
    localparam logic [CTRL_W-1:0]   START_SEED    = 8'h01;  // shifter seed holding the start bit
    localparam logic [SEL_W-1:0]    LAST_CODE     = 4'hB;   // highest code that enables a chip

    // converter mode, control byte bits 1:0
    typedef enum logic [1:0] {
        MODE_FULL_PD  = 2'h0,
        MODE_FAST_PD  = 2'h1,
        MODE_INT_CLK  = 2'h2,
        MODE_EXT_CLK  = 2'h3
    } conv_mode_t;

    // control byte as it arrives, bit 7 at the top
    typedef struct packed {
        logic                start;         // bit 7
        logic [CHAN_W-1:0]   chan_raw;      // bits 6:4: bit 6 weighs 1, bit 5 weighs 4, bit 4 weighs 2
        logic                unipolar;      // bit 3
        logic                single_ended;  // bit 2
        conv_mode_t          mode;          // bits 1:0
    } ctrl_byte_t;

    // decoded configuration of the running conversion
    typedef struct packed {
        conv_mode_t          mode;
        logic                unipolar;
        logic                single_ended;
        logic [CHAN_W-1:0]   channel;
    } conv_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CTRL,
        ST_DATA
    } frame_state_t;

endpackage

// [src/sync2.sv]
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the mclk domain
module sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;   // first stage, read only by the second
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    // next values are plain copies down the chain
    always_comb begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    // both stages clear under reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= nxt_meta;
            sync_out <= nxt_sync;
        end
    end

endmodule

// [dv/host_model.sv]
`timescale 1ns/1ps
// host side of the bank: select code, link clock and control byte, result capture
module host_model (
    input  wire logic       mclk,
    output logic            sclk,   // link clock, stands low outside frames
    output logic            sdin,   // control byte line
    output logic [3:0]      sel,    // chip-select code, bit 3 msb
    input  wire logic       sdout   // result line from the bank
);
    initial begin
        sclk = 1'h0;
        sdin = 1'h0;
        sel  = 4'h0;
    end

    // half of the 160 ns link period, stepped just after mclk edges
    task automatic half();
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // one transaction; abort_at swaps the code before that clock (any clock 1 to 24; 0 swaps none)
    task automatic frame(input logic [3:0] code, input logic [7:0] cbyte, input logic ones,
                         input int abort_at, output logic [15:0] word);
        sel = code;
        for (int k = 1; k <= 24; k++) begin
            if (k == abort_at) begin
                sel = code ^ 4'h1;
            end
            sdin = ones | (k <= 8 && cbyte[8-k]);
            half();
            sclk = 1'h1;
            half();
            // sampled late in the high phase, where the bit is sure to stand
            if (k >= 9) begin
                word[24-k] = sdout;
            end
            sclk = 1'h0;
        end
    endtask

    // park a select code between frames; sole writer of sel stays this model
    task automatic set_sel(input logic [3:0] code);
        sel = code;
    endtask
endmodule

// [dv/monitor_adc_serial_select_test.sv]
`timescale 1ns/1ps
// bench for the converter bank, host model on the serial side
module monitor_adc_serial_select_test;
    import mon_adc_pkg::*;
    logic                  mclk = 1'h0;
    logic                  rst  = 1'h1;
    logic                  sclk;
    logic                  sdin;
    logic                  sdout;
    logic                  active;
    logic [3:0]            sel;
    logic [RESULT_W-1:0]   value;
    logic [NUM_CHIPS-1:0]  cen;
    logic [SEL_W-1:0]      chip;
    conv_cfg_t             cfg;
    logic [15:0]           w;
    int                    errors = 0;
    int                    n_compared = 0;

    always #10 mclk = ~mclk;

    // analog side: a value naming chip and channel, so a wrong pick shows
    assign value = {chip, ~cfg.channel, 5'h15};

    monitor_adc_serial_select monitor_adc_serial_select_inst (
        .mclk(mclk), .rst(rst), .monitor_serial_clock(sclk), .monitor_serial_in(sdin),
        .conv_chip_sel_bit0(sel[0]), .conv_chip_sel_bit1(sel[1]), .conv_chip_sel_bit2(sel[2]),
        .conv_chip_sel_bit3(sel[3]), .conv_value(value), .monitor_serial_out(sdout),
        .chip_enable(cen), .conv_chip(chip), .conv_cfg(cfg), .frame_active(active));

    host_model host_model_inst (.mclk(mclk), .sclk(sclk), .sdin(sdin), .sel(sel), .sdout(sdout));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // null bit, result msb first, zero tail
    function automatic logic [15:0] exp_word(input logic [3:0] c, input logic [2:0] ch);
        return {1'h0, c, ~ch, 5'h15, 3'h0};
    endfunction

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        // the host parks code 0, so the first chip is enabled once the pins settle
        check({cen, chip, 7'(cfg), active, sdout}, {12'h001, 13'h0});
        $display("t_reset done");
    endtask

    // every code, the four idle ones included
    task automatic t_decode();
        for (int c = 0; c < 16; c++) begin
            host_model_inst.set_sel(4'(c));
            repeat (5) @(posedge mclk);
            #1;
            check(cen, (c < 12) ? (32'h1 << c) : 32'h0);
        end
        host_model_inst.frame(4'hD, 8'hFF, 1'h0, 0, w);
        check(w, 32'h0);
        $display("t_decode done");
    endtask

    // all modes, channel codes and flags, frames back to back
    task automatic t_fields();
        logic [2:0] i;
        for (int n = 0; n < 8; n++) begin
            i = 3'(n);
            host_model_inst.frame(4'(n + 4), {1'h1, i, i[0], i[1], i[1:0]}, 1'h0, 0, w);
            check(cfg, {i[1:0], i[0], i[1], i[1], i[0], i[2]});
            check(chip, n + 4);
            check(w, exp_word(4'(n + 4), {i[1], i[0], i[2]}));
        end
        $display("t_fields done");
    endtask

    task automatic t_ones();
        host_model_inst.frame(4'h5, 8'hFF, 1'h1, 0, w);
        check(cfg, 7'h7F);
        check(w, exp_word(4'h5, 3'h7));
        $display("t_ones done");
    endtask

    task automatic t_sweep();
        logic [2:0] ch;
        for (int c = 0; c < 12; c++) begin
            for (int n = 0; n < 8; n++) begin
                ch = 3'(n);
                host_model_inst.frame(4'(c), {1'h1, ch[0], ch[2], ch[1], 4'hF}, 1'h0, 0, w);
                check(w, exp_word(4'(c), ch));
            end
        end
        $display("t_sweep done");
    endtask

    // code change mid-frame drops the frame; the next one still works
    task automatic t_abort();
        host_model_inst.frame(4'h2, 8'h9F, 1'h0, 12, w);
        check({active, sdout}, 32'h0);
        host_model_inst.frame(4'h2, 8'h9F, 1'h0, 0, w);
        check(w, exp_word(4'h2, 3'h2));
        $display("t_abort done");
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        #1;
        rst = 1'h0;
        repeat (4) @(posedge mclk);
        #1;
        t_reset();
        t_decode();
        t_fields();
        t_ones();
        t_sweep();
        t_abort();
        give_verdict();
    end

    // about 110 frames of 192 mclk each should end well inside this span
    initial begin
        #1000000;
        errors++;
        give_verdict();
    end
endmodule
